// ### verilog/irq_src_consts.vh
// Constants for the pin, timer and port-change interrupt source block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef IRQ_SRC_CONSTS_VH
`define IRQ_SRC_CONSTS_VH

// Main interrupt control register bit positions
`define MAIN_PORT_FLAG_BIT     0
`define MAIN_PORT_ENABLE_BIT   3
`define MAIN_TIMER_ENABLE_BIT  5
// Second interrupt control register bit positions
`define SECOND_PORT_PRIO_BIT   0
`define SECOND_THREE_PRIO_BIT  1
`define SECOND_TIMER_PRIO_BIT  2
// Third interrupt control register bit positions
`define THIRD_ONE_PRIO_BIT     6
`define THIRD_TWO_PRIO_BIT     7

// Timer rollover values
`define TIMER_LOW_MAX          8'hFF
`define TIMER_FULL_MAX         16'hFFFF
// Interrupt vector addresses
`define VECTOR_HIGH            21'h00_0008
`define VECTOR_LOW             21'h00_0018
`define VECTOR_RESET           21'h00_0000

// Upper port nibble range watched for change
`define PORT_WATCH_HI          7
`define PORT_WATCH_LO          4
// Number of external pins
`define EXT_PIN_COUNT          4

`endif

// ### verilog/ext_edge_flag.v
// One external interrupt pin: synchroniser, edge detect and sticky flag.
// Assumes the pin is asynchronous to SYS_CLK; clear comes from the same clock.
`timescale 1ns/1ps

module ext_edge_flag
(
  input  wire clk,
  input  wire reset_n,
  input  wire pin,
  input  wire rising_sel,
  input  wire flag_clear,
  output reg  flag,
  output wire edge_seen
);

  reg sync_first;  // Metastability stage, read only by sync_second
  reg sync_second; // Stable sampled level
  reg last_level;  // Previous stable level for edge detect
  reg [2:0] warm;  // Fills with ones as the history gains real pin levels

  // Two-stage synchroniser and history register
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      last_level  <= 1'b0;
      warm        <= 3'h0;
    end
    else
    begin
      sync_first  <= pin;
      sync_second <= sync_first;
      last_level  <= sync_second;
      warm        <= {warm[1:0], 1'h1};
    end
  end

  // Edge of the selected polarity only; masked until the history holds a real
  // pin level, so a pin that idles high gives no false edge after reset
  assign edge_seen = warm[2] &
                     (rising_sel ? (sync_second & ~last_level)
                                 : (~sync_second & last_level));

  // Sticky flag; a new edge wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flag <= 1'b0;
    else if (edge_seen)
      flag <= 1'b1;
    else if (flag_clear)
      flag <= 1'b0;
  end

endmodule

// ### verilog/irq_sources.v
// Interrupt source logic: four edge pins, timer overflow, port-change.
// Assumes the core supplies power mode and global enables as levels and flag
// clears as one-cycle pulses on SYS_CLK; pins and port bits are asynchronous.
`timescale 1ns/1ps
`include "irq_src_consts.vh"

module irq_sources
(
  // Clock and reset
  input  wire        SYS_CLK,
  input  wire        RESET_N,
  // External pins, their edge selects, enables and flags
  input  wire [3:0]  EXT_IRQ_PINS,
  input  wire [3:0]  EXT_EDGE_SELECT,
  input  wire [3:0]  EXT_PIN_ENABLE,
  input  wire [3:0]  EXT_FLAG_CLEAR,
  output wire [3:0]  EXT_PIN_FLAG,
  // Interrupt control bits from the core's registers
  input  wire [7:0]  IRQ_CONTROL_MAIN,
  input  wire [7:0]  IRQ_CONTROL_SECOND,
  input  wire [7:0]  IRQ_CONTROL_THIRD,
  // Timer counter, seen as its count before each tick
  input  wire        TIMER_SIXTEEN_MODE,
  input  wire        TIMER_TICK,
  input  wire [15:0] TIMER_ZERO_COUNT,
  input  wire        TIMER_FLAG_CLEAR,
  output reg         TIMER_OVERFLOW_FLAG,
  // Port pins watched for change
  input  wire [7:0]  PORT_B_PINS,
  input  wire        PORT_FLAG_CLEAR,
  output reg         PORT_CHANGE_FLAG,
  // Core side: global enables, power mode, requests and wake
  input  wire        GLOBAL_HIGH_IRQ_ENABLE,
  input  wire        GLOBAL_LOW_IRQ_ENABLE,
  input  wire        SLEEP_OR_IDLE,
  input  wire        DEEP_SLEEP,
  output wire        HIGH_IRQ_REQUEST,
  output wire        LOW_IRQ_REQUEST,
  output reg         WAKE_PULSE,
  output reg         WAKE_LOAD_VECTOR,
  output reg  [20:0] WAKE_VECTOR
);

  wire [3:0] pin_flag;     // Sticky external flags
  reg  [3:0] port_sync_a;  // First port synchroniser stage
  reg  [3:0] port_sync_b;  // Stable port nibble
  reg  [3:0] port_last;    // Previous stable nibble
  reg  [1:0] port_warm;    // Counts out the synchroniser fill after reset
  reg        port_primed;  // Blocks a false change until the history is real

  // One flag cell per external pin
  // The edge strobe of each cell stays inside it; only the flag is used
  genvar gi;
  generate
    for (gi = 0; gi < `EXT_PIN_COUNT; gi = gi + 1)
    begin : g_pin
      ext_edge_flag u_cell
      (
        .clk        (SYS_CLK),
        .reset_n    (RESET_N),
        .pin        (EXT_IRQ_PINS[gi]),
        .rising_sel (EXT_EDGE_SELECT[gi]),
        .flag_clear (EXT_FLAG_CLEAR[gi]),
        .flag       (pin_flag[gi]),
        .edge_seen  ()
      );
    end
  endgenerate

  assign EXT_PIN_FLAG = pin_flag;

  // Timer rollover: the count shown is the value before the tick, so the
  // wrap is seen one cycle ahead of the counter reaching zero; in eight-bit
  // mode the upper byte is ignored so a running high byte cannot mask it
  wire low_roll  = (TIMER_ZERO_COUNT[7:0] == `TIMER_LOW_MAX);
  wire full_roll = (TIMER_ZERO_COUNT == `TIMER_FULL_MAX);
  wire timer_overflow = TIMER_TICK &
                        (TIMER_SIXTEEN_MODE ? full_roll
                                            : low_roll);

  // Sticky timer flag, set wins over clear
  // A tick that wraps in the clear cycle must not be lost
  always @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      TIMER_OVERFLOW_FLAG <= 1'b0;
    else if (timer_overflow)
      TIMER_OVERFLOW_FLAG <= 1'b1;
    else if (TIMER_FLAG_CLEAR)
      TIMER_OVERFLOW_FLAG <= 1'b0;
  end

  // Port nibble synchroniser and history
  // Only the upper nibble is watched; the lower pins never reach a flag
  always @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      port_sync_a <= 4'h0;
      port_sync_b <= 4'h0;
      port_last   <= 4'h0;
      port_warm   <= 2'h0;
      port_primed <= 1'b0;
    end
    else
    begin
      port_sync_a <= PORT_B_PINS[`PORT_WATCH_HI:`PORT_WATCH_LO];
      port_sync_b <= port_sync_a;
      port_last   <= port_sync_b;
      port_warm   <= {port_warm[0], 1'h1};
      port_primed <= port_warm[1];
    end
  end

  // Priming waits out the reset-to-real level settle to avoid a false flag
  wire port_changed = port_primed & (port_sync_b != port_last);

  // Sticky port-change flag, set wins over clear
  // A change in the clear cycle keeps the flag set
  always @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      PORT_CHANGE_FLAG <= 1'b0;
    else if (port_changed)
      PORT_CHANGE_FLAG <= 1'b1;
    else if (PORT_FLAG_CLEAR)
      PORT_CHANGE_FLAG <= 1'b0;
  end

  // Enable gating: a disabled source keeps its flag but never requests,
  // so enabling it later with the flag still set requests at once
  wire [3:0] pin_active  = pin_flag & EXT_PIN_ENABLE;
  wire timer_active = TIMER_OVERFLOW_FLAG &
                      IRQ_CONTROL_MAIN[`MAIN_TIMER_ENABLE_BIT];
  wire port_active  = PORT_CHANGE_FLAG &
                      IRQ_CONTROL_MAIN[`MAIN_PORT_ENABLE_BIT];

  // Priority per source, one means high
  wire prio_one   = IRQ_CONTROL_THIRD[`THIRD_ONE_PRIO_BIT];
  wire prio_two   = IRQ_CONTROL_THIRD[`THIRD_TWO_PRIO_BIT];
  wire prio_three = IRQ_CONTROL_SECOND[`SECOND_THREE_PRIO_BIT];
  wire prio_timer = IRQ_CONTROL_SECOND[`SECOND_TIMER_PRIO_BIT];
  wire prio_port  = IRQ_CONTROL_SECOND[`SECOND_PORT_PRIO_BIT];

  // Route each active source to its level; pin zero has no priority bit
  // and is wired straight to the high level
  wire any_high = pin_active[0] |
                  (pin_active[1] & prio_one) |
                  (pin_active[2] & prio_two) |
                  (pin_active[3] & prio_three) |
                  (timer_active & prio_timer) |
                  (port_active & prio_port);
  wire any_low  = (pin_active[1] & ~prio_one) |
                  (pin_active[2] & ~prio_two) |
                  (pin_active[3] & ~prio_three) |
                  (timer_active & ~prio_timer) |
                  (port_active & ~prio_port);

  // Requests reach the core gated by the global enables
  // Combinational from the flags, so they drop in the cycle after a flag clear
  assign HIGH_IRQ_REQUEST = any_high & GLOBAL_HIGH_IRQ_ENABLE;
  assign LOW_IRQ_REQUEST  = any_low & GLOBAL_LOW_IRQ_ENABLE;

  // Wake causes; the enable seen now stands for the one set before entry
  // Limitation: the enable is not latched at mode entry, so software must
  // not change enables while the core is asleep
  wire ext_wake   = SLEEP_OR_IDLE & (|pin_active);
  wire other_wake = SLEEP_OR_IDLE & (timer_active | port_active);
  wire deep_wake  = DEEP_SLEEP & pin_active[0];
  wire vector_ok  = (any_high & GLOBAL_HIGH_IRQ_ENABLE) |
                    (any_low & GLOBAL_LOW_IRQ_ENABLE);

  // Wake strobe with the address the core should resume at
  // Deep Sleep wake takes precedence: that mode keeps only pin zero alive
  // and the core must restart as from reset
  always @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WAKE_PULSE       <= 1'b0;
      WAKE_LOAD_VECTOR <= 1'b0;
      WAKE_VECTOR      <= `VECTOR_RESET;
    end
    else if (deep_wake)
    begin
      // Deep Sleep restarts from reset, never an interrupt vector
      WAKE_PULSE       <= 1'b1;
      WAKE_LOAD_VECTOR <= 1'b1;
      WAKE_VECTOR      <= `VECTOR_RESET;
    end
    else if (ext_wake | other_wake)
    begin
      WAKE_PULSE       <= 1'b1;
      WAKE_LOAD_VECTOR <= vector_ok;
      // High level wins when both are pending
      WAKE_VECTOR      <= (any_high & GLOBAL_HIGH_IRQ_ENABLE) ? `VECTOR_HIGH
                                                                : `VECTOR_LOW;
    end
    else
    begin
      // No cause: drop the strobe; the vector holds its last value
      WAKE_PULSE       <= 1'b0;
      WAKE_LOAD_VECTOR <= 1'b0;
    end
  end

endmodule

// ### testbench/timer_model.sv
// Partner: the timer counter, giving its pre-tick count and tick strobe.
// Assumes the block's clock and reset; a load wins over a tick.
`timescale 1ns/1ps
module timer_model
(
  input  wire        clk,
  input  wire        reset_n,
  input  wire        run,
  input  wire        load,
  input  wire [15:0] load_value,
  output wire        tick,
  output reg  [15:0] count
);
  // No tick in a load cycle, so the count shown is always the pre-tick one
  assign tick = run & ~load;
  // Wraps freely through FFFFh, as the real counter does
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      count <= 16'h0000;
    else if (load)
      count <= load_value;
    else if (tick)
      count <= count + 16'h0001;
endmodule

// ### testbench/irq_checker.sv
// Checker: timing relations at the interrupt source block's ports.
// Assumes a bind to irq_sources; one clock, reset async low.
`timescale 1ns/1ps
module irq_checker
(
  input wire        SYS_CLK,
  input wire        RESET_N,
  input wire [3:0]  EXT_IRQ_PINS,
  input wire [3:0]  EXT_EDGE_SELECT,
  input wire [3:0]  EXT_PIN_ENABLE,
  input wire [3:0]  EXT_FLAG_CLEAR,
  input wire [3:0]  EXT_PIN_FLAG,
  input wire [7:0]  IRQ_CONTROL_MAIN,
  input wire [7:0]  IRQ_CONTROL_SECOND,
  input wire        TIMER_SIXTEEN_MODE,
  input wire        TIMER_TICK,
  input wire [15:0] TIMER_ZERO_COUNT,
  input wire        TIMER_OVERFLOW_FLAG,
  input wire [7:0]  PORT_B_PINS,
  input wire        PORT_CHANGE_FLAG,
  input wire        GLOBAL_HIGH_IRQ_ENABLE,
  input wire        GLOBAL_LOW_IRQ_ENABLE,
  input wire        SLEEP_OR_IDLE,
  input wire        DEEP_SLEEP,
  input wire        HIGH_IRQ_REQUEST,
  input wire        LOW_IRQ_REQUEST,
  input wire        WAKE_PULSE,
  input wire [20:0] WAKE_VECTOR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire [3:0] keep = EXT_PIN_FLAG & ~EXT_FLAG_CLEAR;  // Flags that must survive
  wire       both = GLOBAL_HIGH_IRQ_ENABLE & GLOBAL_LOW_IRQ_ENABLE;
  a_eight_bit_wrap: assert property (
    TIMER_TICK && !TIMER_SIXTEEN_MODE && TIMER_ZERO_COUNT[7:0] == 8'hFF
    |=> TIMER_OVERFLOW_FLAG) else $error("eight bit wrap missed");
  a_sixteen_bit_wrap: assert property (
    $rose(TIMER_OVERFLOW_FLAG) && $past(TIMER_SIXTEEN_MODE) |-> $past(TIMER_TICK)
    && $past(TIMER_ZERO_COUNT) == 16'hFFFF) else $error("sixteen bit flag early");
  a_pin_edge_flag: assert property (
    $rose(EXT_IRQ_PINS[0]) && EXT_EDGE_SELECT[0] |-> ##[1:4] EXT_PIN_FLAG[0])
    else $error("rising edge not flagged");
  a_flag_sticky: assert property (
    1'b1 |=> (EXT_PIN_FLAG & $past(keep)) == $past(keep)) else $error("flag lost");
  a_pin_zero_high: assert property (
    EXT_PIN_FLAG[0] && EXT_PIN_ENABLE[0] && GLOBAL_HIGH_IRQ_ENABLE |-> HIGH_IRQ_REQUEST)
    else $error("pin zero not high");
  a_timer_route: assert property (
    TIMER_OVERFLOW_FLAG && IRQ_CONTROL_MAIN[5] && both |->
    (IRQ_CONTROL_SECOND[2] ? HIGH_IRQ_REQUEST : LOW_IRQ_REQUEST)) else $error("timer route");
  a_port_change: assert property (
    $changed(PORT_B_PINS[7:4]) |-> ##[1:4] PORT_CHANGE_FLAG) else $error("port change missed");
  a_wake_high: assert property (
    SLEEP_OR_IDLE && !DEEP_SLEEP && EXT_PIN_FLAG[0] && EXT_PIN_ENABLE[0] && both
    |=> WAKE_PULSE && WAKE_VECTOR == 21'h00_0008) else $error("wake vector wrong");
endmodule

// ### testbench/tb.sv
// Bench: drives the interrupt source block and the timer model.
// Assumes irq_sources, timer_model and irq_checker are compiled first.
`timescale 1ns/1ps
module tb;
  reg         SYS_CLK, RESET_N, mode, run, load, tclr, pclr, gh, gl, slp, deep;
  reg  [3:0]  pins, sel, en, fclr;
  reg  [7:0]  mreg, sreg, treg, port_b_pins;
  reg  [15:0] ldv, rnd;
  wire [3:0]  flag;
  wire [15:0] cnt;
  wire [20:0] vec;
  wire        tick, tflag, pflag, hreq, lreq, wk, wld;
  integer     mismatches, check_count, n, s;
  irq_sources DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .EXT_IRQ_PINS(pins),
    .EXT_EDGE_SELECT(sel), .EXT_PIN_ENABLE(en), .EXT_FLAG_CLEAR(fclr), .EXT_PIN_FLAG(flag),
    .IRQ_CONTROL_MAIN(mreg), .IRQ_CONTROL_SECOND(sreg), .IRQ_CONTROL_THIRD(treg),
    .TIMER_SIXTEEN_MODE(mode), .TIMER_TICK(tick), .TIMER_ZERO_COUNT(cnt),
    .TIMER_FLAG_CLEAR(tclr), .TIMER_OVERFLOW_FLAG(tflag), .PORT_B_PINS(port_b_pins),
    .PORT_FLAG_CLEAR(pclr), .PORT_CHANGE_FLAG(pflag), .GLOBAL_HIGH_IRQ_ENABLE(gh),
    .GLOBAL_LOW_IRQ_ENABLE(gl), .SLEEP_OR_IDLE(slp), .DEEP_SLEEP(deep),
    .HIGH_IRQ_REQUEST(hreq), .LOW_IRQ_REQUEST(lreq), .WAKE_PULSE(wk),
    .WAKE_LOAD_VECTOR(wld), .WAKE_VECTOR(vec));
  timer_model tm (.clk(SYS_CLK), .reset_n(RESET_N), .run(run), .load(load),
    .load_value(ldv), .tick(tick), .count(cnt));
  // Random source
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected level of pin p: pin zero has no priority bit
  function exp_high(input [1:0] p, input [7:0] s2, input [7:0] s3);
    exp_high = (p == 2'h0) | (p == 2'h1 & s3[6]) | (p == 2'h2 & s3[7]) | (p == 2'h3 & s2[1]);
  endfunction
  task step(input integer k);
    repeat (k) @(negedge SYS_CLK);
  endtask
  task chk(input [23:0] got, input [23:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Loads the timer with its flag cleared, then gives two ticks
  task spin(input [15:0] v);
    begin
      ldv = v;
      {load, tclr} = 2'h3;
      step(1);
      {load, tclr, run} = 3'h1;
      step(2);
      run = 0;
      step(1);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial
  begin
    SYS_CLK = 0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #50000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
  initial
  begin
    {RESET_N, pins, sel, en, fclr, mreg, sreg, treg, port_b_pins, ldv} = 0;
    {mode, run, load, tclr, pclr, slp, deep, gh, gl} = 9'h003;
    {rnd, mismatches, check_count} = {16'h659B, 64'h0};
    step(20);
    RESET_N = 1;
    step(2);
    // Wrong edge leaves the flag clear; right edge sets it, disabled, and it holds
    for (n = 0; n < 8; n = n + 1)
    begin
      s = n % 2;
      sel[n/2] = s;
      pins[n/2] = s;
      step(5);
      fclr[n/2] = 1;
      step(1);
      fclr[n/2] = 0;
      pins[n/2] = !s;
      step(5);
      chk(flag[n/2], 1'h0);
      pins[n/2] = s;
      step(5);
      chk(flag[n/2], 1'h1);
      step(9);
      chk({hreq, lreq, flag[n/2]}, 3'h1);
    end
    // Random priority bits, one pin enabled at a time
    for (n = 0; n < 16; n = n + 1)
    begin
      rnd = lfsr(rnd);
      {treg, sreg} = rnd;
      en = 4'h1 << n[1:0];
      step(1);
      s = exp_high(n[1:0], sreg, treg);
      chk({hreq, lreq}, {s[0], !s[0]});
    end
    // Sleep wake high then low, then no vector load with both global enables
    // off; deep sleep only pin zero, reset vector
    {treg, en, slp} = 13'h0003;
    step(2);
    chk({wk, wld, vec}, {2'h3, 21'h00_0008});
    en = 4'h2;
    step(2);
    chk({wk, wld, vec}, {2'h3, 21'h00_0018});
    {gh, gl} = 2'h0;
    step(2);
    chk({wk, wld}, 2'h2);
    {gh, gl} = 2'h3;
    {en, slp, deep} = 6'h05;
    step(2);
    chk({wld, vec}, {1'h1, 21'h00_0000});
    en = 4'h2;
    step(2);
    chk(wk, 1'h0);
    {en, deep} = 5'h00;
    // Low byte wrap only counts in eight-bit mode
    spin(16'h12FE);
    chk(tflag, 1'h1);
    mode = 1;
    spin(16'h12FE);
    chk(tflag, 1'h0);
    spin(16'hFFFE);
    chk(tflag, 1'h1);
    mreg = 8'h20;
    for (n = 0; n < 2; n = n + 1)
    begin
      sreg[2] = n;
      step(1);
      chk({hreq, lreq}, {sreg[2], !sreg[2]});
    end
    // Lower port nibble ignored; upper nibble change flags and requests high
    {mreg, sreg, pclr} = 17'h0_1003;
    step(1);
    pclr = 0;
    rnd = lfsr(rnd);
    port_b_pins = {4'h0, rnd[3:0] | 4'h1};
    step(5);
    chk({pflag, hreq, lreq}, 3'h0);
    port_b_pins[7:4] = rnd[7:4] | 4'h8;
    step(5);
    chk({pflag, hreq, lreq}, 3'h6);
    // Port-change at low priority, then disabled with its flag kept
    sreg = 8'h00;
    step(1);
    chk({hreq, lreq}, 2'h1);
    mreg = 8'h00;
    step(1);
    chk({pflag, hreq, lreq}, 3'h4);
    report_and_stop;
  end
endmodule

bind irq_sources irq_checker chk_i (.*);
